/* File: common/eec_regs.svh */
// Register offsets, field positions and constants of the enclave entry control block
`ifndef EEC_REGS_SVH
`define EEC_REGS_SVH

`define EEC_A_CMD 8'h00
`define EEC_A_RAX 8'h04
`define EEC_A_RBX 8'h08
`define EEC_A_RCX 8'h0C
`define EEC_A_NEXT_IP 8'h10
`define EEC_A_TFLAGS 8'h14
`define EEC_A_ENTRY_POINT_OFFSET 8'h18
`define EEC_A_OFSB 8'h1C
`define EEC_A_OFSL 8'h20
`define EEC_A_OGSB 8'h24
`define EEC_A_OGSL 8'h28
`define EEC_A_CURRENT_SAVE_FRAME_INDEX 8'h2C
`define EEC_A_ENCLAVE_CONTROL_STRUCT_BASE 8'h30
`define EEC_A_ENCLAVE_CONTROL_STRUCT_ATTR 8'h34
`define EEC_A_ENCLAVE_FEATURE_MASK 8'h38
`define EEC_A_CTRL 8'h3C
`define EEC_A_DS_LIM 8'h40
`define EEC_A_CS_LIM 8'h44
`define EEC_A_EXTENDED_CONTROL_REG_ZERO 8'h48
`define EEC_A_RSP 8'h4C
`define EEC_A_RBP 8'h50
`define EEC_A_STATUS 8'h54
`define EEC_A_SSA_RSP 8'h58
`define EEC_A_SSA_RBP 8'h5C
`define EEC_A_EXTENDED_CONTROL_REG_ZERO_SV 8'h60
`define EEC_A_AEP 8'h64
`define EEC_A_FS_B 8'h68
`define EEC_A_FS_L 8'h6C
`define EEC_A_GS_B 8'h70
`define EEC_A_GS_L 8'h74
`define EEC_A_RIP 8'h78
`define EEC_A_PERF_HI 8'h7C

// Command bits
`define EEC_CMD_GO 0
`define EEC_CMD_EXIT 1
`define EEC_CMD_AEX 2

// Control bits
`define EEC_C_WIDE_MODE_ATTRIBUTE 0
`define EEC_C_FXSR 1
`define EEC_C_XSAVE 2
`define EEC_C_OPTIN 3
`define EEC_C_TVALID 4
`define EEC_C_TLOCK 5
`define EEC_C_SBUSY 6
`define EEC_C_SEGNZ 7
`define EEC_C_PEND 8
`define EEC_C_CONFL 9
`define EEC_C_TF 10

// Status bits
`define EEC_S_BUSY 0
`define EEC_S_ENC 1
`define EEC_S_FAULT 2
`define EEC_S_CAUSE_LO 4
`define EEC_S_STEP 8
`define EEC_S_PMU 9
`define EEC_S_PRECISE_EVENT_SAMPLING 10
`define EEC_S_BPOUT 11
`define EEC_S_BPIN 12
`define EEC_S_DEMOTE 13
`define EEC_S_TFSV 14

// Fault causes, all reported as a protection fault with code zero
`define EEC_F_NONE 4'h0
`define EEC_F_ALIGN 4'h1
`define EEC_F_TCS 4'h2
`define EEC_F_FLAGS 4'h3
`define EEC_F_MODE 4'h4
`define EEC_F_FSGS 4'h5
`define EEC_F_SEG 4'h6
`define EEC_F_XSAVE 4'h7
`define EEC_F_TARGET 4'h8
`define EEC_F_CONFL 4'h9
`define EEC_F_LEAF 4'hA
`define EEC_F_INENC 4'hB

`define EEC_LEAF_ENTER 32'h0000_0002
`define EEC_TCS_ALIGN 32'h0000_0FFF
`define EEC_FLAGS_MBZ 32'hFFFF_FFFE
`define EEC_ENCLAVE_FEATURE_MASK_LEGACY 32'h0000_0003
`define EEC_ALL_ONES 32'hFFFF_FFFF
// Bits 60 and 63 of the 64-bit global status, as seen in its upper word
`define EEC_PERF_B60 28
`define EEC_PERF_B63 31
`define EEC_HTRANS_NONSEQ 2'h2

`endif

/* File: common/eec_pkg.sv */
// Types of the enclave entry control block
package eec_pkg;

	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} eec_ahb_req_t;

	typedef struct packed {
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
	} eec_ahb_rsp_t;

	typedef enum logic [1:0] {
		EEC_IDLE = 2'b00,
		EEC_DRAIN = 2'b01,
		EEC_CHECK = 2'b10,
		EEC_COMMIT = 2'b11
	} eec_fsm_t;

	typedef struct packed {
		eec_fsm_t fsm;
		logic hready;
		logic hresp;
		logic [31:0] hrdata;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rax, rbx, rcx, next_ip, tflags, entry_point_offset, ofsb, ofsl, ogsb, ogsl, current_save_frame_index;
		logic [31:0] enclave_control_struct_base, enclave_feature_mask, ds_lim, cs_lim, extended_control_reg_zero, rsp, rbp;
		logic [31:0] ssa_rsp, ssa_rbp, extended_control_reg_zero_sv, async_exit_pointer, fs_b, fs_l, gs_b, gs_l;
		logic [31:0] fs_b_sv, fs_l_sv, gs_b_sv, gs_l_sv, rip, perf_hi;
		logic [10:0] ctrl;
		logic wide_attr;
		logic enc, fault, step, pmu, precise_event_sampling, bp_out, bp_in, demote, tf_sv, xsw, optout;
		logic [3:0] cause;
	} eec_state_t;

endpackage

/* File: logic/eec_entry.sv */
// Enclave entry control: operand registers, entry checks, state build and exit restore over AHB-Lite
//
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "eec_regs.svh"

module eec_entry #(
	parameter int VA_W = 28
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire eec_pkg::eec_ahb_req_t ahb_i,
	output eec_pkg::eec_ahb_rsp_t ahb_o
);

	localparam eec_pkg::eec_state_t ST_RST = '{fsm: eec_pkg::EEC_IDLE, hready: 1'b1, default: '0};

	eec_pkg::eec_state_t st_r;
	eec_pkg::eec_state_t st_nxt;

	function automatic logic canon(input logic [31:0] a);
		canon = (a[31:VA_W-1] == '0) || (a[31:VA_W-1] == '1);
	endfunction

	function automatic logic [31:0] rd_mux(input eec_pkg::eec_state_t s, input logic [7:0] a);
		logic [31:0] stat;
		stat = '0;
		stat[`EEC_S_BUSY] = (s.fsm != eec_pkg::EEC_IDLE);
		stat[`EEC_S_ENC] = s.enc;
		stat[`EEC_S_FAULT] = s.fault;
		stat[`EEC_S_CAUSE_LO +: 4] = s.cause;
		stat[`EEC_S_STEP] = s.step;
		stat[`EEC_S_PMU] = s.pmu;
		stat[`EEC_S_PRECISE_EVENT_SAMPLING] = s.precise_event_sampling;
		stat[`EEC_S_BPOUT] = s.bp_out;
		stat[`EEC_S_BPIN] = s.bp_in;
		stat[`EEC_S_DEMOTE] = s.demote;
		stat[`EEC_S_TFSV] = s.tf_sv;
		case (a)
			`EEC_A_RAX: rd_mux = s.rax;
			`EEC_A_RBX: rd_mux = s.rbx;
			`EEC_A_RCX: rd_mux = s.rcx;
			`EEC_A_NEXT_IP: rd_mux = s.next_ip;
			`EEC_A_TFLAGS: rd_mux = s.tflags;
			`EEC_A_ENTRY_POINT_OFFSET: rd_mux = s.entry_point_offset;
			`EEC_A_OFSB: rd_mux = s.ofsb;
			`EEC_A_OFSL: rd_mux = s.ofsl;
			`EEC_A_OGSB: rd_mux = s.ogsb;
			`EEC_A_OGSL: rd_mux = s.ogsl;
			`EEC_A_CURRENT_SAVE_FRAME_INDEX: rd_mux = s.current_save_frame_index;
			`EEC_A_ENCLAVE_CONTROL_STRUCT_BASE: rd_mux = s.enclave_control_struct_base;
			`EEC_A_ENCLAVE_CONTROL_STRUCT_ATTR: rd_mux = {31'h0000_0000, s.wide_attr};
			`EEC_A_ENCLAVE_FEATURE_MASK: rd_mux = s.enclave_feature_mask;
			`EEC_A_CTRL: rd_mux = {21'h00_0000, s.ctrl};
			`EEC_A_DS_LIM: rd_mux = s.ds_lim;
			`EEC_A_CS_LIM: rd_mux = s.cs_lim;
			`EEC_A_EXTENDED_CONTROL_REG_ZERO: rd_mux = s.extended_control_reg_zero;
			`EEC_A_RSP: rd_mux = s.rsp;
			`EEC_A_RBP: rd_mux = s.rbp;
			`EEC_A_STATUS: rd_mux = stat;
			`EEC_A_SSA_RSP: rd_mux = s.ssa_rsp;
			`EEC_A_SSA_RBP: rd_mux = s.ssa_rbp;
			`EEC_A_EXTENDED_CONTROL_REG_ZERO_SV: rd_mux = s.extended_control_reg_zero_sv;
			`EEC_A_AEP: rd_mux = s.async_exit_pointer;
			`EEC_A_FS_B: rd_mux = s.fs_b;
			`EEC_A_FS_L: rd_mux = s.fs_l;
			`EEC_A_GS_B: rd_mux = s.gs_b;
			`EEC_A_GS_L: rd_mux = s.gs_l;
			`EEC_A_RIP: rd_mux = s.rip;
			`EEC_A_PERF_HI: rd_mux = s.perf_hi;
			default: rd_mux = '0;
		endcase
	endfunction

	// Entry checks, all from current register contents
	logic m64;
	logic [31:0] fs_base, fs_lim, gs_base, gs_lim, target;
	logic bad_leaf, bad_align, bad_tcs, bad_flags, bad_mode, bad_fsgs, bad_seg, bad_xsave, bad_target, bad_confl;
	logic [3:0] cause_now;

	assign m64 = st_r.ctrl[`EEC_C_WIDE_MODE_ATTRIBUTE];
	assign fs_base = st_r.ofsb + st_r.enclave_control_struct_base;
	assign fs_lim = fs_base + st_r.ofsl;
	assign gs_base = st_r.ogsb + st_r.enclave_control_struct_base;
	assign gs_lim = gs_base + st_r.ogsl;
	assign target = st_r.entry_point_offset + st_r.enclave_control_struct_base;
	assign bad_leaf = (st_r.rax != `EEC_LEAF_ENTER);
	assign bad_align = ((st_r.rbx & `EEC_TCS_ALIGN) != '0);
	assign bad_tcs = !st_r.ctrl[`EEC_C_TVALID] || st_r.ctrl[`EEC_C_TLOCK] || st_r.ctrl[`EEC_C_SBUSY];
	assign bad_flags = ((st_r.tflags & `EEC_FLAGS_MBZ) != '0);
	assign bad_mode = (m64 != st_r.wide_attr);
	// Outside 64-bit mode a wrapping segment is only legal when DS spans the whole space
	assign bad_fsgs = m64 ? (!canon(fs_base) || !canon(gs_base)) :
		(((fs_lim < fs_base) ? (st_r.ds_lim != `EEC_ALL_ONES) : (fs_lim > st_r.ds_lim)) ||
		((gs_lim < gs_base) ? (st_r.ds_lim != `EEC_ALL_ONES) : (gs_lim > st_r.ds_lim)));
	assign bad_seg = st_r.ctrl[`EEC_C_SEGNZ];
	assign bad_xsave = !st_r.ctrl[`EEC_C_FXSR] ||
		(!st_r.ctrl[`EEC_C_XSAVE] && (st_r.enclave_feature_mask != `EEC_ENCLAVE_FEATURE_MASK_LEGACY)) ||
		(st_r.ctrl[`EEC_C_XSAVE] && ((st_r.enclave_feature_mask & ~st_r.extended_control_reg_zero) != '0));
	assign bad_target = m64 ? !canon(target) : (target > st_r.cs_lim);
	// Only an exclusive holder conflicts; the other leaves share the structure
	assign bad_confl = st_r.ctrl[`EEC_C_CONFL];

	always_comb begin
		cause_now = `EEC_F_NONE;
		if (bad_leaf) cause_now = `EEC_F_LEAF;
		else if (bad_align) cause_now = `EEC_F_ALIGN;
		else if (bad_confl) cause_now = `EEC_F_CONFL;
		else if (bad_tcs) cause_now = `EEC_F_TCS;
		else if (bad_fsgs) cause_now = `EEC_F_FSGS;
		else if (bad_flags) cause_now = `EEC_F_FLAGS;
		else if (bad_mode) cause_now = `EEC_F_MODE;
		else if (bad_seg) cause_now = `EEC_F_SEG;
		else if (bad_xsave) cause_now = `EEC_F_XSAVE;
		else if (bad_target) cause_now = `EEC_F_TARGET;
	end

	always_comb begin
		logic wr;
		logic [31:0] d;
		logic go, ex, async_enclave_exit;
		st_nxt = st_r;
		wr = st_r.wr_pend;
		d = ahb_i.hwdata;
		go = 1'b0;
		ex = 1'b0;
		async_enclave_exit = 1'b0;
		st_nxt.hready = 1'b1;
		st_nxt.hresp = 1'b0;
		// Data phase of a write completes now; address phase of the next transfer is taken
		st_nxt.wr_pend = 1'b0;
		if (ahb_i.hsel && ahb_i.hready && ahb_i.htrans == `EEC_HTRANS_NONSEQ) begin
			st_nxt.wr_pend = ahb_i.hwrite && (ahb_i.haddr[31:8] == '0);
			st_nxt.wr_addr = ahb_i.haddr[7:0];
			st_nxt.hrdata = (ahb_i.haddr[31:8] == '0) ? rd_mux(st_r, ahb_i.haddr[7:0]) : '0;
		end
		if (wr) begin
			case (st_r.wr_addr)
				`EEC_A_CMD: begin
					go = d[`EEC_CMD_GO];
					ex = d[`EEC_CMD_EXIT];
					async_enclave_exit = d[`EEC_CMD_AEX];
				end
				`EEC_A_RAX: st_nxt.rax = d;
				`EEC_A_RBX: st_nxt.rbx = d;
				`EEC_A_RCX: st_nxt.rcx = d;
				`EEC_A_NEXT_IP: st_nxt.next_ip = d;
				`EEC_A_TFLAGS: st_nxt.tflags = d;
				`EEC_A_ENTRY_POINT_OFFSET: st_nxt.entry_point_offset = d;
				`EEC_A_OFSB: st_nxt.ofsb = d;
				`EEC_A_OFSL: st_nxt.ofsl = d;
				`EEC_A_OGSB: st_nxt.ogsb = d;
				`EEC_A_OGSL: st_nxt.ogsl = d;
				`EEC_A_CURRENT_SAVE_FRAME_INDEX: st_nxt.current_save_frame_index = d;
				`EEC_A_ENCLAVE_CONTROL_STRUCT_BASE: st_nxt.enclave_control_struct_base = d;
				`EEC_A_ENCLAVE_CONTROL_STRUCT_ATTR: st_nxt.wide_attr = d[0];
				`EEC_A_ENCLAVE_FEATURE_MASK: st_nxt.enclave_feature_mask = d;
				`EEC_A_CTRL: begin
					st_nxt.ctrl = d[10:0];
					// Setting the trap flag inside an opt-out enclave leaves it clear
					if (st_r.enc && st_r.optout) st_nxt.ctrl[`EEC_C_TF] = 1'b0;
				end
				`EEC_A_DS_LIM: st_nxt.ds_lim = d;
				`EEC_A_CS_LIM: st_nxt.cs_lim = d;
				`EEC_A_EXTENDED_CONTROL_REG_ZERO: st_nxt.extended_control_reg_zero = d;
				`EEC_A_RSP: st_nxt.rsp = d;
				`EEC_A_RBP: st_nxt.rbp = d;
				`EEC_A_STATUS: begin
					if (d[`EEC_S_FAULT]) st_nxt.fault = 1'b0;
					if (d[`EEC_S_STEP]) st_nxt.step = 1'b0;
				end
				`EEC_A_FS_B: st_nxt.fs_b = d;
				`EEC_A_FS_L: st_nxt.fs_l = d;
				`EEC_A_GS_B: st_nxt.gs_b = d;
				`EEC_A_GS_L: st_nxt.gs_l = d;
				`EEC_A_PERF_HI: st_nxt.perf_hi = st_r.perf_hi & ~d;
				default: ;
			endcase
		end
		case (st_r.fsm)
			eec_pkg::EEC_IDLE: begin
				if (go && st_r.enc) begin
					st_nxt.fault = 1'b1;
					st_nxt.cause = `EEC_F_INENC;
				end else if (go) begin
					st_nxt.fsm = eec_pkg::EEC_DRAIN;
				end else if ((ex || async_enclave_exit) && st_r.enc) begin
					st_nxt.enc = 1'b0;
					st_nxt.rsp = st_r.ssa_rsp;
					st_nxt.rbp = st_r.ssa_rbp;
					st_nxt.fs_b = st_r.fs_b_sv;
					st_nxt.fs_l = st_r.fs_l_sv;
					st_nxt.gs_b = st_r.gs_b_sv;
					st_nxt.gs_l = st_r.gs_l_sv;
					if (st_r.xsw) st_nxt.extended_control_reg_zero = st_r.extended_control_reg_zero_sv;
					if (st_r.optout) st_nxt.ctrl[`EEC_C_TF] = st_r.tf_sv;
					st_nxt.xsw = 1'b0;
					st_nxt.optout = 1'b0;
					st_nxt.pmu = 1'b0;
					st_nxt.precise_event_sampling = 1'b0;
					st_nxt.bp_out = 1'b0;
					st_nxt.bp_in = 1'b0;
					st_nxt.demote = 1'b0;
				end
			end
			eec_pkg::EEC_DRAIN: begin
				if (!st_r.ctrl[`EEC_C_PEND]) st_nxt.fsm = eec_pkg::EEC_CHECK;
			end
			eec_pkg::EEC_CHECK: begin
				// Nothing architectural changes unless every check passes
				if (cause_now != `EEC_F_NONE) begin
					st_nxt.fault = 1'b1;
					st_nxt.cause = cause_now;
					st_nxt.fsm = eec_pkg::EEC_IDLE;
				end else begin
					st_nxt.fsm = eec_pkg::EEC_COMMIT;
				end
			end
			eec_pkg::EEC_COMMIT: begin
				st_nxt.fsm = eec_pkg::EEC_IDLE;
				st_nxt.cause = `EEC_F_NONE;
				st_nxt.enc = 1'b1;
				st_nxt.rip = target;
				st_nxt.rax = st_r.current_save_frame_index;
				st_nxt.rcx = st_r.next_ip;
				st_nxt.async_exit_pointer = st_r.rcx;
				st_nxt.ssa_rsp = st_r.rsp;
				st_nxt.ssa_rbp = st_r.rbp;
				st_nxt.fs_b_sv = st_r.fs_b;
				st_nxt.fs_l_sv = st_r.fs_l;
				st_nxt.gs_b_sv = st_r.gs_b;
				st_nxt.gs_l_sv = st_r.gs_l;
				st_nxt.fs_b = fs_base;
				st_nxt.gs_b = gs_base;
				if (!m64) begin
					st_nxt.fs_l = st_r.ofsl;
					st_nxt.gs_l = st_r.ogsl;
				end
				if (st_r.ctrl[`EEC_C_XSAVE]) begin
					st_nxt.extended_control_reg_zero_sv = st_r.extended_control_reg_zero;
					st_nxt.extended_control_reg_zero = st_r.enclave_feature_mask;
					st_nxt.xsw = 1'b1;
				end
				st_nxt.bp_out = 1'b1;
				if (st_r.ctrl[`EEC_C_OPTIN]) begin
					st_nxt.step = 1'b1;
				end else begin
					st_nxt.optout = 1'b1;
					st_nxt.tf_sv = st_r.ctrl[`EEC_C_TF];
					st_nxt.ctrl[`EEC_C_TF] = 1'b0;
					st_nxt.bp_in = 1'b1;
					st_nxt.pmu = 1'b1;
					st_nxt.precise_event_sampling = 1'b1;
					st_nxt.demote = 1'b1;
					// Set after any software clear in this cycle, so the set wins
					st_nxt.perf_hi[`EEC_PERF_B60] = 1'b1;
					st_nxt.perf_hi[`EEC_PERF_B63] = 1'b1;
				end
			end
			default: st_nxt.fsm = eec_pkg::EEC_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign ahb_o = '{hreadyout: st_r.hready, hresp: st_r.hresp, hrdata: st_r.hrdata};

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_leaf_code_gate: assert property ((st_r.fsm == eec_pkg::EEC_CHECK) && bad_leaf
		|=> st_r.fault && (st_r.cause == `EEC_F_LEAF) && (st_r.fsm == eec_pkg::EEC_IDLE))
		else $error("wrong leaf code not faulted");
	a_entry_rip_set: assert property ((st_r.fsm == eec_pkg::EEC_COMMIT)
		|=> st_r.enc && (st_r.rip == $past(st_r.entry_point_offset) + $past(st_r.enclave_control_struct_base)))
		else $error("entry pointer wrong after commit");
	a_target_fault: assert property ((st_r.fsm == eec_pkg::EEC_CHECK) && bad_target
		|=> st_r.fault && !st_r.enc)
		else $error("bad target did not fault");
	a_drain_hold: assert property ((st_r.fsm == eec_pkg::EEC_DRAIN) && st_r.ctrl[`EEC_C_PEND]
		|=> st_r.fsm == eec_pkg::EEC_DRAIN)
		else $error("entry left drain with older work pending");
	a_fault_no_change: assert property ((st_r.fsm == eec_pkg::EEC_CHECK) && (cause_now != `EEC_F_NONE)
		|=> $stable(st_r.rip) && $stable(st_r.async_exit_pointer) && $stable(st_r.fs_b) && $stable(st_r.ssa_rsp))
		else $error("faulting entry changed state");
	a_rsp_saved: assert property ((st_r.fsm == eec_pkg::EEC_COMMIT)
		|=> (st_r.ssa_rsp == $past(st_r.rsp)) && (st_r.ssa_rbp == $past(st_r.rbp)))
		else $error("stack pointers not saved");
	a_aep_stored: assert property ((st_r.fsm == eec_pkg::EEC_COMMIT)
		|=> (st_r.async_exit_pointer == $past(st_r.rcx)) && (st_r.rcx == $past(st_r.next_ip)))
		else $error("exit pointer not stored");
	a_extended_control_reg_zero_swap: assert property ((st_r.fsm == eec_pkg::EEC_COMMIT) && st_r.ctrl[`EEC_C_XSAVE]
		|=> (st_r.extended_control_reg_zero == $past(st_r.enclave_feature_mask)) && (st_r.extended_control_reg_zero_sv == $past(st_r.extended_control_reg_zero)))
		else $error("control register zero not swapped");
	a_tf_optout: assert property ((st_r.fsm == eec_pkg::EEC_COMMIT) && !st_r.ctrl[`EEC_C_OPTIN]
		|=> !st_r.ctrl[`EEC_C_TF] && (st_r.tf_sv == $past(st_r.ctrl[`EEC_C_TF])))
		else $error("trap flag not saved and cleared");
	a_step_optin: assert property ((st_r.fsm == eec_pkg::EEC_COMMIT) && st_r.ctrl[`EEC_C_OPTIN]
		|=> st_r.step && !st_r.bp_in && st_r.bp_out)
		else $error("single step not pended");
	a_perf_bits: assert property ((st_r.fsm == eec_pkg::EEC_COMMIT) && !st_r.ctrl[`EEC_C_OPTIN]
		|=> st_r.perf_hi[`EEC_PERF_B60] && st_r.perf_hi[`EEC_PERF_B63] && st_r.pmu && st_r.precise_event_sampling)
		else $error("monitoring status bits not set");
	a_align_fault: assert property ((st_r.fsm == eec_pkg::EEC_CHECK) && !bad_leaf && bad_align
		|=> st_r.fault && (st_r.cause == `EEC_F_ALIGN))
		else $error("misaligned structure address not faulted");
	a_confl_fault: assert property ((st_r.fsm == eec_pkg::EEC_CHECK) && bad_confl
		&& !bad_leaf && !bad_align
		|=> st_r.fault && (st_r.cause == `EEC_F_CONFL))
		else $error("structure conflict not faulted");
	a_tcs_fault: assert property ((st_r.fsm == eec_pkg::EEC_CHECK) && bad_tcs
		|=> st_r.fault && !st_r.enc && (st_r.fsm == eec_pkg::EEC_IDLE))
		else $error("unusable thread structure not faulted");
	a_flags_fault: assert property ((st_r.fsm == eec_pkg::EEC_CHECK) && bad_flags
		|=> st_r.fault && !st_r.enc && (st_r.fsm == eec_pkg::EEC_IDLE))
		else $error("reserved flags bit not faulted");
	a_mode_fault: assert property ((st_r.fsm == eec_pkg::EEC_CHECK) && bad_mode
		|=> st_r.fault && !st_r.enc && (st_r.fsm == eec_pkg::EEC_IDLE))
		else $error("mode mismatch not faulted");
	a_fsgs_fault: assert property ((st_r.fsm == eec_pkg::EEC_CHECK) && bad_fsgs
		|=> st_r.fault && !st_r.enc && (st_r.fsm == eec_pkg::EEC_IDLE))
		else $error("segment outside data segment not faulted");
	a_seg_fault: assert property ((st_r.fsm == eec_pkg::EEC_CHECK) && bad_seg
		|=> st_r.fault && !st_r.enc && (st_r.fsm == eec_pkg::EEC_IDLE))
		else $error("nonzero segment not faulted");
	a_xsave_fault: assert property ((st_r.fsm == eec_pkg::EEC_CHECK) && bad_xsave
		|=> st_r.fault && !st_r.enc && (st_r.fsm == eec_pkg::EEC_IDLE))
		else $error("bad extended save setting not faulted");
	a_rax_return: assert property ((st_r.fsm == eec_pkg::EEC_COMMIT)
		|=> st_r.rax == $past(st_r.current_save_frame_index))
		else $error("save index not returned");
	a_fs_build: assert property ((st_r.fsm == eec_pkg::EEC_COMMIT)
		|=> (st_r.fs_b == $past(st_r.ofsb) + $past(st_r.enclave_control_struct_base)) && (st_r.fs_b_sv == $past(st_r.fs_b))
		&& (st_r.gs_b == $past(st_r.ogsb) + $past(st_r.enclave_control_struct_base)) && (st_r.gs_b_sv == $past(st_r.gs_b)))
		else $error("segment bases not rebuilt");
	a_lim_build: assert property ((st_r.fsm == eec_pkg::EEC_COMMIT) && !m64
		|=> (st_r.fs_l == $past(st_r.ofsl)) && (st_r.gs_l == $past(st_r.ogsl)))
		else $error("segment limits not rebuilt");
	a_bp_inside: assert property ((st_r.fsm == eec_pkg::EEC_COMMIT) && !st_r.ctrl[`EEC_C_OPTIN]
		|=> st_r.bp_in && st_r.bp_out)
		else $error("breakpoints not suppressed on opt-out");
	a_demote_thr: assert property ((st_r.fsm == eec_pkg::EEC_COMMIT) && !st_r.ctrl[`EEC_C_OPTIN]
		|=> st_r.demote && st_r.perf_hi[`EEC_PERF_B60])
		else $error("all-thread counting not demoted");
	a_exit_restore: assert property ((st_r.fsm == eec_pkg::EEC_IDLE) && st_r.enc && st_r.wr_pend
		&& (st_r.wr_addr == `EEC_A_CMD) && !ahb_i.hwdata[`EEC_CMD_GO]
		&& (ahb_i.hwdata[`EEC_CMD_EXIT] || ahb_i.hwdata[`EEC_CMD_AEX])
		|=> !st_r.enc && (st_r.rsp == $past(st_r.ssa_rsp)) && (st_r.rbp == $past(st_r.ssa_rbp)))
		else $error("stack pointers not restored on exit");
	a_tf_held: assert property (st_r.enc && st_r.optout |-> !st_r.ctrl[`EEC_C_TF])
		else $error("trap flag set inside opt-out enclave");
	a_bp_out_enc: assert property (st_r.enc |-> st_r.bp_out)
		else $error("outside breakpoints active in enclave");
	a_pmu_held: assert property (st_r.enc && st_r.optout |-> st_r.pmu && st_r.precise_event_sampling && st_r.demote)
		else $error("monitoring not suppressed in opt-out enclave");

endmodule

/* File: verification/test_enclave_entry_control.sv */
// Self-checking bench for the enclave entry control block, driven over its register bus
`timescale 1ns/1ps
`include "eec_regs.svh"

module test_enclave_entry_control;
	localparam logic [31:0] full = `EEC_ALL_ONES;
	logic hclk;
	logic hresetn;
	logic m_sel;
	logic [31:0] m_addr;
	logic [1:0] m_trans;
	logic m_write;
	logic [31:0] m_wdata;
	int mismatches;
	int compares;
	eec_pkg::eec_ahb_req_t req;
	eec_pkg::eec_ahb_rsp_t rsp;

	// The single slave's ready closes the loop as the bus ready
	assign req = '{hsel: m_sel, haddr: m_addr, htrans: m_trans, hwrite: m_write, hsize: 3'h2,
		hwdata: m_wdata, hready: rsp.hreadyout};

	eec_entry #(.VA_W(28)) dut_u (.hclk(hclk), .hresetn(hresetn), .ahb_i(req), .ahb_o(rsp));

	always #25 hclk = ~hclk;

	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (rsp.hreadyout !== 1'b1 && n < 100);
		if (rsp.hreadyout !== 1'b1) begin
			mismatches++;
			final_report();
		end
	endtask

	// One single transfer: address phase held until ready, then data phase until ready
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		m_sel <= 1'b1;
		m_addr <= a;
		m_trans <= `EEC_HTRANS_NONSEQ;
		m_write <= w;
		wait_rdy();
		m_trans <= 2'h0;
		m_wdata <= d;
		wait_rdy();
		q = rsp.hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic rc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0000_0000, q);
		chk({31'h0000_0000, rsp.hresp}, 32'h0000_0000);
		chk(q & m, e);
	endtask

	// Issue a command, then poll until the entry sequence is idle again
	task automatic go_wait(input logic [31:0] cmd);
		logic [31:0] q;
		int n;
		wr(`EEC_A_CMD, cmd);
		n = 0;
		do begin
			xfer(1'b0, `EEC_A_STATUS, 32'h0000_0000, q);
			n++;
		end while (q[`EEC_S_BUSY] !== 1'b0 && n < 50);
		if (q[`EEC_S_BUSY] !== 1'b0) begin
			mismatches++;
			final_report();
		end
	endtask

	// Legal set-up: opt-out entry with extended save, 32-bit or 64-bit mode
	task automatic base(input logic w);
		wr(`EEC_A_RAX, 32'h0000_0002);
		wr(`EEC_A_RBX, 32'h0000_3000);
		wr(`EEC_A_RCX, 32'h0000_1234);
		wr(`EEC_A_NEXT_IP, 32'h0000_0500);
		wr(`EEC_A_TFLAGS, 32'h0000_0001);
		wr(`EEC_A_ENTRY_POINT_OFFSET, 32'h0000_0100);
		wr(`EEC_A_OFSB, 32'h0000_2000);
		wr(`EEC_A_OFSL, 32'h0000_0FFF);
		wr(`EEC_A_OGSB, 32'h0000_3000);
		wr(`EEC_A_OGSL, 32'h0000_0FFF);
		wr(`EEC_A_CURRENT_SAVE_FRAME_INDEX, 32'h0000_0005);
		wr(`EEC_A_ENCLAVE_CONTROL_STRUCT_BASE, 32'h0001_0000);
		wr(`EEC_A_ENCLAVE_CONTROL_STRUCT_ATTR, {31'h0, w});
		wr(`EEC_A_ENCLAVE_FEATURE_MASK, 32'h0000_0003);
		wr(`EEC_A_CTRL, {31'h0000_020B, w});
		wr(`EEC_A_DS_LIM, 32'h000F_FFFF);
		wr(`EEC_A_CS_LIM, 32'h000F_FFFF);
		wr(`EEC_A_EXTENDED_CONTROL_REG_ZERO, 32'h0000_0007);
		wr(`EEC_A_RSP, 32'hAAAA_0000);
		wr(`EEC_A_RBP, 32'hBBBB_0000);
	endtask

	// A faulting entry must report its cause and leave earlier state untouched
	task automatic fcase(input logic w, input logic [31:0] a1, input logic [31:0] d1,
		input logic [31:0] a2, input logic [31:0] d2, input logic [3:0] c);
		base(w);
		wr(a1, d1);
		wr(a2, d2);
		wr(`EEC_A_RSP, 32'hCCCC_0000);
		go_wait(32'h0000_0001);
		rc(`EEC_A_STATUS, 32'h0000_00F7, {24'h0, c, 4'h4});
		rc(`EEC_A_RCX, full, 32'h0000_1234);
		rc(`EEC_A_SSA_RSP, full, 32'hAAAA_0000);
		wr(`EEC_A_STATUS, 32'h0000_0004);
	endtask

	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		m_sel = 1'b0;
		m_addr = 32'h0000_0000;
		m_trans = 2'h0;
		m_write = 1'b0;
		m_wdata = 32'h0000_0000;
		mismatches = 0;
		compares = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		rc(`EEC_A_STATUS, full, 32'h0000_0000);
		wr(32'h0000_0104, 32'h5A5A_5A5A);
		rc(`EEC_A_RAX, full, 32'h0000_0000);
		rc(32'h0000_0104, full, 32'h0000_0000);
		// Opt-out entry in 32-bit mode, held back while older operations are pending
		base(1'b0);
		wr(`EEC_A_CTRL, 32'h0000_0516);
		wr(`EEC_A_CMD, 32'h0000_0001);
		rc(`EEC_A_STATUS, 32'h0000_0003, 32'h0000_0001);
		rc(`EEC_A_STATUS, 32'h0000_0003, 32'h0000_0001);
		wr(`EEC_A_CTRL, 32'h0000_0416);
		go_wait(32'h0000_0000);
		rc(`EEC_A_STATUS, 32'h0000_FFFF, 32'h0000_7E02);
		rc(`EEC_A_RAX, full, 32'h0000_0005);
		rc(`EEC_A_RCX, full, 32'h0000_0500);
		rc(`EEC_A_RIP, full, 32'h0001_0100);
		rc(`EEC_A_AEP, full, 32'h0000_1234);
		rc(`EEC_A_SSA_RSP, full, 32'hAAAA_0000);
		rc(`EEC_A_SSA_RBP, full, 32'hBBBB_0000);
		rc(`EEC_A_FS_B, full, 32'h0001_2000);
		rc(`EEC_A_GS_B, full, 32'h0001_3000);
		rc(`EEC_A_EXTENDED_CONTROL_REG_ZERO, full, 32'h0000_0003);
		rc(`EEC_A_EXTENDED_CONTROL_REG_ZERO_SV, full, 32'h0000_0007);
		rc(`EEC_A_PERF_HI, full, 32'h9000_0000);
		rc(`EEC_A_CTRL, full, 32'h0000_0016);
		wr(`EEC_A_CTRL, 32'h0000_0416);
		rc(`EEC_A_CTRL, full, 32'h0000_0016);
		wr(`EEC_A_RSP, 32'h0000_0000);
		wr(`EEC_A_RBP, 32'h0000_0000);
		go_wait(32'h0000_0002);
		rc(`EEC_A_STATUS, 32'h0000_0002, 32'h0000_0000);
		rc(`EEC_A_CTRL, full, 32'h0000_0416);
		rc(`EEC_A_RSP, full, 32'hAAAA_0000);
		rc(`EEC_A_RBP, full, 32'hBBBB_0000);
		rc(`EEC_A_EXTENDED_CONTROL_REG_ZERO, full, 32'h0000_0007);
		wr(`EEC_A_PERF_HI, 32'h9000_0000);
		// Opt-in entry in 64-bit mode without extended save, then a second go inside
		base(1'b1);
		wr(`EEC_A_CTRL, 32'h0000_001B);
		go_wait(32'h0000_0001);
		rc(`EEC_A_STATUS, 32'h0000_FFFF, 32'h0000_4902);
		rc(`EEC_A_RIP, full, 32'h0001_0100);
		rc(`EEC_A_EXTENDED_CONTROL_REG_ZERO, full, 32'h0000_0007);
		rc(`EEC_A_PERF_HI, full, 32'h0000_0000);
		go_wait(32'h0000_0001);
		rc(`EEC_A_STATUS, 32'h0000_00F6, 32'h0000_00B6);
		wr(`EEC_A_STATUS, 32'h0000_0004);
		wr(`EEC_A_RSP, 32'h0000_0000);
		go_wait(32'h0000_0004);
		rc(`EEC_A_STATUS, 32'h0000_0006, 32'h0000_0000);
		rc(`EEC_A_RSP, full, 32'hAAAA_0000);
		// One broken condition at a time
		fcase(1'b0, `EEC_A_RAX, 32'h3, `EEC_A_RAX, 32'h3, `EEC_F_LEAF);
		fcase(1'b0, `EEC_A_RBX, 32'h3010, `EEC_A_RBX, 32'h3010, `EEC_F_ALIGN);
		fcase(1'b0, `EEC_A_CTRL, 32'h616, `EEC_A_CTRL, 32'h616, `EEC_F_CONFL);
		fcase(1'b0, `EEC_A_CTRL, 32'h406, `EEC_A_CTRL, 32'h406, `EEC_F_TCS);
		fcase(1'b0, `EEC_A_CTRL, 32'h436, `EEC_A_CTRL, 32'h436, `EEC_F_TCS);
		fcase(1'b0, `EEC_A_CTRL, 32'h456, `EEC_A_CTRL, 32'h456, `EEC_F_TCS);
		fcase(1'b0, `EEC_A_OFSL, 32'hF_0000, `EEC_A_OFSL, 32'hF_0000, `EEC_F_FSGS);
		fcase(1'b0, `EEC_A_OGSB, 32'hF_0000, `EEC_A_OGSB, 32'hF_0000, `EEC_F_FSGS);
		fcase(1'b0, `EEC_A_OFSL, 32'hFFFF_FFFF, `EEC_A_OFSL, 32'hFFFF_FFFF, `EEC_F_FSGS);
		fcase(1'b1, `EEC_A_OFSB, 32'h800_0000, `EEC_A_OFSB, 32'h800_0000, `EEC_F_FSGS);
		fcase(1'b0, `EEC_A_TFLAGS, 32'h2, `EEC_A_TFLAGS, 32'h2, `EEC_F_FLAGS);
		fcase(1'b0, `EEC_A_ENCLAVE_CONTROL_STRUCT_ATTR, 32'h1, `EEC_A_ENCLAVE_CONTROL_STRUCT_ATTR, 32'h1, `EEC_F_MODE);
		fcase(1'b0, `EEC_A_CTRL, 32'h496, `EEC_A_CTRL, 32'h496, `EEC_F_SEG);
		fcase(1'b0, `EEC_A_CTRL, 32'h414, `EEC_A_CTRL, 32'h414, `EEC_F_XSAVE);
		fcase(1'b0, `EEC_A_ENCLAVE_FEATURE_MASK, 32'hF, `EEC_A_ENCLAVE_FEATURE_MASK, 32'hF, `EEC_F_XSAVE);
		fcase(1'b0, `EEC_A_CTRL, 32'h412, `EEC_A_ENCLAVE_FEATURE_MASK, 32'h7, `EEC_F_XSAVE);
		fcase(1'b0, `EEC_A_ENTRY_POINT_OFFSET, 32'h10_0000, `EEC_A_ENTRY_POINT_OFFSET, 32'h10_0000, `EEC_F_TARGET);
		fcase(1'b1, `EEC_A_ENTRY_POINT_OFFSET, 32'h800_0000, `EEC_A_ENTRY_POINT_OFFSET, 32'h800_0000, `EEC_F_TARGET);
		final_report();
	end

	// Cuts a hang short
	initial begin
		repeat (60000) @(posedge hclk);
		mismatches++;
		final_report();
	end
endmodule
